/* verilog/rtc_ctrl.sv */
// control, status and interval timer logic of the calendar clock
// What this block does
// (RULE1) address 15 reaches calendar setup when bank bit is 0, interval setup when 1
// (RULE2) calendar setup: bit0 hour mode, bit1 pm, bits 3:2 leap count
// (RULE3) leap count zero means leap year; processor reads and writes it
// (RULE4) interval code picks none, 0.1, 0.5, 1, 5, 10, 30, 60 seconds
// (RULE5) writing code zero clears interrupt and forces timer halt bit to one
// (RULE6) after a nonzero code, timer waits for halt bit written zero
// (RULE7) single mode stops at timeout until halt bit written zero again
// (RULE8) repeat mode keeps counting and interrupting with no processor help
// (RULE9) writing halt bit one stops and resets timer; restart gives full period
// (RULE10) address 0 writes four control latches, reads a separate status word
// (RULE11) control bit 3 one enters test mode, zero restores normal
// (RULE12) control bit 2 one halts time and zeros tenths; zero restarts
// (RULE13) control bit 0 zero runs timer, one halts and resets it
// (RULE14) status read: changed flag bit 3, zeros bits 2:1, timer flag bit 0
// (RULE15) setting pulse sets changed flag; only control read clears it
// (RULE16) timeout sets timer flag and drives interrupt low; control read clears both
// (RULE17) flags clear at end of read strobe and hold stable during read
// (RULE18) timeout during control read is kept and shown after the read
// (RULE19) setting pulse during control read leaves changed flag unchanged
// (RULE20) interval bit 3 zero single mode, one repeat mode
// (RULE21) time and changed flag step on the 10 Hz setting pulse
// (RULE22) pm bit reads zero morning, one afternoon
// (RULE23) 4-bit data, 4-bit address, active-low select, read and write strobes
`timescale 1ns/1ps
`default_nettype none
module rtc_ctrl #(
   // setting pulse spacing in clocks; the interval timer paces on the same count
   parameter int unsigned PULSE_CYCLES = rtc_ctrl_pkg::SET_PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [3:0] addr,
   input wire logic [3:0] data_in,
   output logic [3:0] data_out,
   output logic data_oe,
   output logic irq_out,
   output logic irq_oe,
   output logic test_mode,
   output logic clock_halted,
   output logic [3:0] tenths_count,
   input wire logic am_pm_toggle,
   input wire logic leap_advance
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [4:0] ctl_meta_reg;
   logic [4:0] ctl_sync_reg;
   logic [7:0] bus_meta_reg;
   logic [7:0] bus_sync_reg;
   logic [1:0] evt_meta_reg;
   logic [1:0] evt_sync_reg;
   logic [1:0] evt_last_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         ctl_meta_reg <= 5'h1f;
         ctl_sync_reg <= 5'h1f;
         bus_meta_reg <= 8'h00;
         bus_sync_reg <= 8'h00;
         evt_meta_reg <= 2'h0;
         evt_sync_reg <= 2'h0;
         evt_last_reg <= 2'h0;
      end else begin
         ctl_meta_reg <= {cs_n, rd_n, wr_n, 2'b11};
         ctl_sync_reg <= ctl_meta_reg;
         bus_meta_reg <= {addr, data_in};
         bus_sync_reg <= bus_meta_reg;
         evt_meta_reg <= {am_pm_toggle, leap_advance};
         evt_sync_reg <= evt_meta_reg;
         evt_last_reg <= evt_sync_reg;
      end
   end

   logic sel;
   logic rd_act;
   logic wr_act;
   logic [3:0] a_s;
   logic [3:0] d_s;
   assign sel = !ctl_sync_reg[4];
   assign a_s = bus_sync_reg[7:4];
   assign d_s = bus_sync_reg[3:0];
   // [RULE23]
   assign rd_act = sel && !ctl_sync_reg[3];
   assign wr_act = sel && !ctl_sync_reg[2];

   logic wr_last_reg;
   logic ctl_rd_last_reg;
   logic wr_pulse;
   logic ctl_rd_act;
   logic ctl_rd_end;
   assign ctl_rd_act = rd_act && a_s == rtc_ctrl_pkg::ADDR_CONTROL;
   assign wr_pulse = wr_act && !wr_last_reg;
   // clear at trailing edge of strobe, not leading [RULE17]
   assign ctl_rd_end = ctl_rd_last_reg && !ctl_rd_act;

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_last_reg <= 1'b0;
         ctl_rd_last_reg <= 1'b0;
      end else begin
         wr_last_reg <= wr_act;
         ctl_rd_last_reg <= ctl_rd_act;
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [3:0] control_reg;
   logic [3:0] calendar_setup_reg;
   logic [3:0] alarm_interval_setup_reg;
   logic wr_ctl;
   logic wr_cal;
   logic wr_ivl;
   logic ivl_zero_wr;
   assign wr_ctl = wr_pulse && a_s == rtc_ctrl_pkg::ADDR_CONTROL; // [RULE10]
   assign wr_cal = wr_pulse && a_s == rtc_ctrl_pkg::ADDR_SETUP
      && !control_reg[rtc_ctrl_pkg::CTL_BANK_SEL]; // [RULE1]
   assign wr_ivl = wr_pulse && a_s == rtc_ctrl_pkg::ADDR_SETUP
      && control_reg[rtc_ctrl_pkg::CTL_BANK_SEL]; // [RULE1]
   assign ivl_zero_wr = wr_ivl && d_s[2:0] == 3'b000;

   // a same-time control write takes priority over the zero interval write forcing halt
   always_ff @(posedge clk) begin
      if (reset) begin
         control_reg <= rtc_ctrl_pkg::CONTROL_RESET;
      end else if (wr_ctl) begin
         control_reg <= d_s; // [RULE11] [RULE12] [RULE13]
      end else if (ivl_zero_wr) begin
         control_reg[rtc_ctrl_pkg::CTL_TIMER_HALT] <= 1'b1; // [RULE5]
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         alarm_interval_setup_reg <= rtc_ctrl_pkg::INTERVAL_RESET;
      end else if (wr_ivl) begin
         alarm_interval_setup_reg <= d_s; // [RULE4] [RULE20]
      end
   end

   // leap count advances on year roll; pm toggles at 11:59 to 12:00 [RULE22]
   always_ff @(posedge clk) begin
      if (reset) begin
         calendar_setup_reg <= rtc_ctrl_pkg::SETUP_RESET;
      end else if (wr_cal) begin
         calendar_setup_reg <= d_s; // [RULE2] [RULE3]
      end else begin
         if (evt_sync_reg[1] && !evt_last_reg[1]) begin
            calendar_setup_reg[rtc_ctrl_pkg::CAL_PM] <= !calendar_setup_reg[rtc_ctrl_pkg::CAL_PM];
         end
         if (evt_sync_reg[0] && !evt_last_reg[0]) begin
            calendar_setup_reg[3:2] <= calendar_setup_reg[3:2] + 2'b01; // [RULE3]
         end
      end
   end

   // ----------------------------------------
   // setting pulse and tenths counter
   // ----------------------------------------
   rtc_tick_if tick ();
   assign tick.run = !control_reg[rtc_ctrl_pkg::CTL_CLOCK_HALT]; // [RULE12]
   rtc_tick_gen #(.PULSE_CYCLES(PULSE_CYCLES)) u_tick (
      .clk(clk),
      .reset(reset),
      .tick(tick.source)
   );

   always_ff @(posedge clk) begin
      if (reset || control_reg[rtc_ctrl_pkg::CTL_CLOCK_HALT]) begin
         tenths_count <= 4'h0; // [RULE12]
      end else if (tick.set_pulse) begin
         tenths_count <= (tenths_count == 4'h9) ? 4'h0 : tenths_count + 4'h1; // [RULE21]
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         test_mode <= 1'b0;
         clock_halted <= rtc_ctrl_pkg::CONTROL_RESET[rtc_ctrl_pkg::CTL_CLOCK_HALT];
      end else begin
         test_mode <= control_reg[rtc_ctrl_pkg::CTL_TEST]; // [RULE11]
         clock_halted <= control_reg[rtc_ctrl_pkg::CTL_CLOCK_HALT];
      end
   end

   // ----------------------------------------
   // interval timer
   // ----------------------------------------
   logic [9:0] ivl_len;
   always_comb begin
      unique case (alarm_interval_setup_reg[2:0]) // [RULE4]
         3'd1: ivl_len = rtc_ctrl_pkg::TICKS_0P1;
         3'd2: ivl_len = rtc_ctrl_pkg::TICKS_0P5;
         3'd3: ivl_len = rtc_ctrl_pkg::TICKS_1;
         3'd4: ivl_len = rtc_ctrl_pkg::TICKS_5;
         3'd5: ivl_len = rtc_ctrl_pkg::TICKS_10;
         3'd6: ivl_len = rtc_ctrl_pkg::TICKS_30;
         3'd7: ivl_len = rtc_ctrl_pkg::TICKS_60;
         3'd0: ivl_len = 10'd0;
      endcase
   end

   logic [9:0] ivl_count_reg;
   logic single_done_reg;
   logic timer_run;
   logic timeout;
   // timer paces on the free 10 Hz rate of its own so clock halt does not stop it
   logic [31:0] ivl_div_reg;
   logic ivl_tick;
   assign timer_run = !control_reg[rtc_ctrl_pkg::CTL_TIMER_HALT]
      && alarm_interval_setup_reg[2:0] != 3'b000 && !single_done_reg; // [RULE6] [RULE13]
   assign ivl_tick = ivl_div_reg == PULSE_CYCLES - 1;
   assign timeout = timer_run && ivl_tick && ivl_count_reg == ivl_len - 10'd1;

   always_ff @(posedge clk) begin
      if (reset || !timer_run) begin
         ivl_div_reg <= 32'h0000_0000; // [RULE9]
      end else if (ivl_tick) begin
         ivl_div_reg <= 32'h0000_0000;
      end else begin
         ivl_div_reg <= ivl_div_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !timer_run) begin
         ivl_count_reg <= 10'd0; // [RULE9] [RULE13]
      end else if (timeout) begin
         ivl_count_reg <= 10'd0; // [RULE8]
      end else if (ivl_tick) begin
         ivl_count_reg <= ivl_count_reg + 10'd1;
      end
   end

   // single mode parks until a fresh zero is written to the halt bit
   always_ff @(posedge clk) begin
      if (reset) begin
         single_done_reg <= 1'b0;
      end else if (wr_ctl && !d_s[rtc_ctrl_pkg::CTL_TIMER_HALT]) begin
         single_done_reg <= 1'b0; // [RULE7]
      end else if (timeout && !alarm_interval_setup_reg[rtc_ctrl_pkg::IVL_REPEAT]) begin
         single_done_reg <= 1'b1; // [RULE7] [RULE20]
      end
   end

   // ----------------------------------------
   // status flags
   // ----------------------------------------
   logic changed_flag_reg;
   logic timer_flag_reg;
   logic pend_timeout_reg;

   // set wins over the trailing-edge clear
   always_ff @(posedge clk) begin
      if (reset) begin
         changed_flag_reg <= 1'b0;
      end else if (tick.set_pulse && !ctl_rd_act) begin
         changed_flag_reg <= 1'b1; // [RULE15] [RULE19] [RULE21]
      end else if (ctl_rd_end) begin
         changed_flag_reg <= 1'b0; // [RULE15] [RULE17]
      end
   end

   always_ff @(posedge clk) begin
      if (reset || ivl_zero_wr) begin
         pend_timeout_reg <= 1'b0;
      end else if (timeout && ctl_rd_act) begin
         pend_timeout_reg <= 1'b1; // [RULE18]
      end else if (!ctl_rd_act) begin
         pend_timeout_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || ivl_zero_wr) begin
         timer_flag_reg <= 1'b0; // [RULE5]
      end else if ((timeout && !ctl_rd_act) || (pend_timeout_reg && !ctl_rd_act)) begin
         timer_flag_reg <= 1'b1; // [RULE16] [RULE18]
      end else if (ctl_rd_end) begin
         timer_flag_reg <= 1'b0; // [RULE16] [RULE17]
      end
   end

   // ----------------------------------------
   // pins
   // ----------------------------------------
   // open drain: only ever drive low
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_out <= 1'b0;
         irq_oe <= 1'b0;
      end else begin
         irq_out <= 1'b0;
         irq_oe <= timer_flag_reg; // [RULE16]
      end
   end

   // status held during the whole control read [RULE17]
   always_ff @(posedge clk) begin
      if (reset) begin
         data_out <= 4'h0;
         data_oe <= 1'b0;
      end else begin
         data_oe <= rd_act;
         if (ctl_rd_act && !ctl_rd_last_reg) begin
            data_out <= {changed_flag_reg, 2'b00, timer_flag_reg}; // [RULE14]
         end else if (rd_act && a_s == rtc_ctrl_pkg::ADDR_SETUP) begin
            data_out <= control_reg[rtc_ctrl_pkg::CTL_BANK_SEL]
               ? alarm_interval_setup_reg : calendar_setup_reg; // [RULE1]
         end else if (!ctl_rd_act) begin
            data_out <= 4'h0;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_zero_code_halts: assert property (@(posedge clk) disable iff (reset)
      ivl_zero_wr && !wr_ctl |=> control_reg[0] && !timer_flag_reg) else $error("zero code did not halt"); // [RULE5]
   a_halt_blocks_timeout: assert property (@(posedge clk) disable iff (reset)
      control_reg[0] |-> !timeout) else $error("timeout while halted"); // [RULE13]
   a_single_parks: assert property (@(posedge clk) disable iff (reset)
      timeout && !alarm_interval_setup_reg[3] && !wr_ctl |=> !timer_run) else $error("single mode kept running"); // [RULE7]
   a_repeat_continues: assert property (@(posedge clk) disable iff (reset)
      timeout && alarm_interval_setup_reg[3] && !wr_ctl && !wr_ivl |=> timer_run) else $error("repeat stopped"); // [RULE8]
   a_flags_held_read: assert property (@(posedge clk) disable iff (reset)
      ctl_rd_act && $past(ctl_rd_act) |-> $stable(changed_flag_reg)) else $error("changed flag moved in read"); // [RULE19]
   a_no_irq_in_read: assert property (@(posedge clk) disable iff (reset)
      ctl_rd_act && $past(ctl_rd_act) && !$past(timer_flag_reg) |-> !timer_flag_reg) else $error("irq during read"); // [RULE18]
   a_read_end_clears: assert property (@(posedge clk) disable iff (reset)
      ctl_rd_end && !timeout && !pend_timeout_reg && !tick.set_pulse |=> !timer_flag_reg && !changed_flag_reg)
      else $error("flags not cleared"); // [RULE17]
   a_irq_follows_flag: assert property (@(posedge clk) disable iff (reset)
      timer_flag_reg |=> irq_oe && !irq_out) else $error("irq pin not low"); // [RULE16]
   a_halt_zeros_tenths: assert property (@(posedge clk) disable iff (reset)
      control_reg[2] |=> tenths_count == 4'h0) else $error("tenths not reset"); // [RULE12]
endmodule
`default_nettype wire

/* verilog/rtc_ctrl_pkg.sv */
// shared constants for the calendar clock control and interval timer
package rtc_ctrl_pkg;
   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_SETUP = 4'hf;
   // ----------------------------------------
   // control write latch positions
   // ----------------------------------------
   localparam int CTL_TIMER_HALT = 0;
   localparam int CTL_BANK_SEL = 1;
   localparam int CTL_CLOCK_HALT = 2;
   localparam int CTL_TEST = 3;
   // ----------------------------------------
   // status read positions
   // ----------------------------------------
   localparam int STAT_TIMER_FLAG = 0;
   localparam int STAT_CHANGED_FLAG = 3;
   // ----------------------------------------
   // calendar setup and interval fields
   // ----------------------------------------
   localparam int CAL_HOUR_MODE = 0;
   localparam int CAL_PM = 1;
   localparam int CAL_LEAP_LO = 2;
   localparam int IVL_REPEAT = 3;
   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [3:0] CONTROL_RESET = 4'h1;
   localparam logic [3:0] SETUP_RESET = 4'h0;
   localparam logic [3:0] INTERVAL_RESET = 4'h0;
   // ----------------------------------------
   // timing: 10 Hz setting pulse from 50 MHz
   // ----------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int SET_PULSE_HZ = 10;
   localparam int SET_PULSE_CYCLES = CLK_HZ / SET_PULSE_HZ;
   // interval lengths, in setting pulses (tenths of seconds)
   localparam logic [9:0] TICKS_0P1 = 10'd1;
   localparam logic [9:0] TICKS_0P5 = 10'd5;
   localparam logic [9:0] TICKS_1 = 10'd10;
   localparam logic [9:0] TICKS_5 = 10'd50;
   localparam logic [9:0] TICKS_10 = 10'd100;
   localparam logic [9:0] TICKS_30 = 10'd300;
   localparam logic [9:0] TICKS_60 = 10'd600;
endpackage

/* verilog/rtc_tick_if.sv */
// carrier between the pulse divider and the control logic
`timescale 1ns/1ps
`default_nettype none
interface rtc_tick_if;
   logic set_pulse;
   logic run;
   modport source (output set_pulse, input run);
   modport sink (input set_pulse, output run);
endinterface
`default_nettype wire

/* verilog/rtc_tick_gen.sv */
// divider making the one-cycle 10 Hz clock setting pulse
`timescale 1ns/1ps
`default_nettype none
module rtc_tick_gen #(
   parameter int unsigned PULSE_CYCLES = rtc_ctrl_pkg::SET_PULSE_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   rtc_tick_if.source tick
);
   logic [31:0] count_reg;

   // halting clears the phase so a restart gives a whole tenth [RULE12]
   always_ff @(posedge clk) begin
      if (reset || !tick.run) begin
         count_reg <= 32'h0000_0000;
         tick.set_pulse <= 1'b0;
      end else if (count_reg == PULSE_CYCLES - 1) begin
         count_reg <= 32'h0000_0000;
         tick.set_pulse <= 1'b1; // [RULE21]
      end else begin
         count_reg <= count_reg + 32'h0000_0001;
         tick.set_pulse <= 1'b0;
      end
   end

   a_pulse_single: assert property (@(posedge clk) disable iff (reset)
      tick.set_pulse |=> !tick.set_pulse) else $error("setting pulse longer than one cycle"); // [RULE21]
endmodule
`default_nettype wire

/* dv/rtc_bus_host.sv */
// processor side model of the 4-bit register bus
`timescale 1ns/1ps
`default_nettype none
module rtc_bus_host (
   input wire logic clk,
   output logic cs_n,
   output logic rd_n,
   output logic wr_n,
   output logic [3:0] addr,
   output logic [3:0] data_in,
   input wire logic [3:0] data_out,
   input wire logic data_oe
);
   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      addr = 4'h0;
      data_in = 4'h0;
   end

   // ----------------------------------------
   // bus cycles, changed on the falling edge
   // ----------------------------------------
   // address and data set up two cycles ahead, since the strobes pass two sync flops
   task automatic write_reg(input logic [3:0] a, input logic [3:0] d);
      @(negedge clk);
      addr = a;
      data_in = d;
      repeat (2) @(negedge clk);
      cs_n = 1'b0;
      wr_n = 1'b0;
      repeat (4) @(negedge clk);
      cs_n = 1'b1;
      wr_n = 1'b1;
      // released lines show the inverse so a stale value cannot pass
      addr = ~a;
      data_in = ~d;
      repeat (4) @(negedge clk);
   endtask

   task automatic read_reg(input logic [3:0] a, output logic [3:0] d, output logic oe);
      @(negedge clk);
      addr = a;
      repeat (2) @(negedge clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      repeat (6) @(negedge clk);
      d = data_out;
      oe = data_oe;
      cs_n = 1'b1;
      rd_n = 1'b1;
      addr = ~a;
      repeat (4) @(negedge clk);
   endtask
endmodule
`default_nettype wire

/* dv/rtc_control_and_interrupt_timer_test.sv */
// self-checking bench for the calendar clock control block
`timescale 1ns/1ps
`default_nettype none
module rtc_control_and_interrupt_timer_test;
   logic clk, reset, cs_n, rd_n, wr_n, data_oe, irq_out, irq_oe;
   logic test_mode, clock_halted, am_pm_toggle, leap_advance, rd_oe;
   logic [3:0] addr, data_in, data_out, tenths_count, rd_val;
   int err_count;
   int cmp_count;
   typedef struct {logic [3:0] ctl; logic [3:0] a; logic [3:0] wd; logic [3:0] exp;} row_s;
   // each row: control word, target address, written word, expected read
   row_s rows [10] = '{'{4'h5, 4'hf, 4'hc, 4'hc}, '{4'h5, 4'hf, 4'h2, 4'h2},
      '{4'h7, 4'hf, 4'h1, 4'h1}, '{4'h7, 4'hf, 4'ha, 4'ha}, '{4'h7, 4'hf, 4'h3, 4'h3},
      '{4'h7, 4'hf, 4'hc, 4'hc}, '{4'h7, 4'hf, 4'h5, 4'h5}, '{4'h7, 4'hf, 4'he, 4'he},
      '{4'h7, 4'hf, 4'h7, 4'h7}, '{4'h7, 4'h5, 4'ha, 4'h0}};

   rtc_ctrl #(.PULSE_CYCLES(40)) uut (.clk(clk), .reset(reset), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .irq_out(irq_out), .irq_oe(irq_oe),
      .test_mode(test_mode), .clock_halted(clock_halted), .tenths_count(tenths_count),
      .am_pm_toggle(am_pm_toggle), .leap_advance(leap_advance));

   rtc_bus_host host (.clk(clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // level inputs: one rising edge, held long enough for the sync flops
   task automatic bump(input bit pm);
      @(negedge clk);
      if (pm) begin
         am_pm_toggle = 1'b1;
      end else begin
         leap_advance = 1'b1;
      end
      repeat (4) @(negedge clk);
      am_pm_toggle = 1'b0;
      leap_advance = 1'b0;
      repeat (4) @(negedge clk);
   endtask

   task automatic idle_outputs();
      check("irq_oe", {3'h0, irq_oe}, 4'h0);
      check("irq_out", {3'h0, irq_out}, 4'h0);
      check("data_oe", {3'h0, data_oe}, 4'h0);
      check("tenths", tenths_count, 4'h0);
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // whole run needs well under 3000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      summarize();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      err_count = 0;
      cmp_count = 0;
      reset = 1'b1;
      am_pm_toggle = 1'b0;
      leap_advance = 1'b0;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      idle_outputs();
      check("test_mode", {3'h0, test_mode}, 4'h0);
      check("clock free", {3'h0, clock_halted}, 4'h0);
      $display("test reset done");

      for (int i = 0; i < 10; i++) begin
         host.write_reg(rtc_ctrl_pkg::ADDR_CONTROL, rows[i].ctl);
         host.write_reg(rows[i].a, rows[i].wd);
         host.read_reg(rows[i].a, rd_val, rd_oe);
         check("row read", rd_val, rows[i].exp);
      end
      $display("test table done");

      // bank switch must not disturb the other register
      host.write_reg(rtc_ctrl_pkg::ADDR_CONTROL, 4'h5);
      host.read_reg(rtc_ctrl_pkg::ADDR_SETUP, rd_val, rd_oe);
      check("calendar kept", rd_val, 4'h2);
      check("read enable", {3'h0, rd_oe}, 4'h1);
      host.write_reg(rtc_ctrl_pkg::ADDR_CONTROL, 4'h6);
      host.read_reg(rtc_ctrl_pkg::ADDR_SETUP, rd_val, rd_oe);
      check("interval kept", rd_val, 4'h7);
      $display("test banks done");

      // zero code while the timer runs: no interrupt, code reads back zero
      host.write_reg(rtc_ctrl_pkg::ADDR_SETUP, 4'h0);
      host.read_reg(rtc_ctrl_pkg::ADDR_SETUP, rd_val, rd_oe);
      check("zero code", rd_val, 4'h0);
      check("irq after zero", {3'h0, irq_oe}, 4'h0);
      // status word, not the latched 4'h7; no setting pulse has come yet
      host.read_reg(rtc_ctrl_pkg::ADDR_CONTROL, rd_val, rd_oe);
      check("status", rd_val, 4'h0);
      $display("test status done");

      host.write_reg(rtc_ctrl_pkg::ADDR_CONTROL, 4'h8);
      check("test on", {3'h0, test_mode}, 4'h1);
      check("clock run", {3'h0, clock_halted}, 4'h0);
      host.write_reg(rtc_ctrl_pkg::ADDR_CONTROL, 4'h4);
      check("test off", {3'h0, test_mode}, 4'h0);
      check("clock stop", {3'h0, clock_halted}, 4'h1);
      check("tenths zero", tenths_count, 4'h0);
      $display("test control latches done");

      // leap count 3 plus one wraps to 0, the leap year
      host.write_reg(rtc_ctrl_pkg::ADDR_SETUP, 4'hc);
      bump(1'b1);
      host.read_reg(rtc_ctrl_pkg::ADDR_SETUP, rd_val, rd_oe);
      check("pm set", rd_val, 4'he);
      bump(1'b0);
      host.read_reg(rtc_ctrl_pkg::ADDR_SETUP, rd_val, rd_oe);
      check("leap wrap", rd_val, 4'h2);
      bump(1'b0);
      host.read_reg(rtc_ctrl_pkg::ADDR_SETUP, rd_val, rd_oe);
      check("leap step", rd_val, 4'h6);
      $display("test counters done");

      // single then repeat mode at the 0.1 s code; waits counted from the run write
      for (int m = 0; m < 2; m++) begin
         host.write_reg(rtc_ctrl_pkg::ADDR_CONTROL, 4'h7);
         host.write_reg(rtc_ctrl_pkg::ADDR_SETUP, {m[0], 3'b001});
         host.write_reg(rtc_ctrl_pkg::ADDR_CONTROL, 4'h6);
         repeat (40) @(negedge clk);
         check("irq first", {3'h0, irq_oe}, 4'h1);
         check("irq level", {3'h0, irq_out}, 4'h0);
         host.read_reg(rtc_ctrl_pkg::ADDR_CONTROL, rd_val, rd_oe);
         check("irq status", rd_val, 4'h1);
         check("irq cleared", {3'h0, irq_oe}, 4'h0);
         repeat (30) @(negedge clk);
         check("irq again", {3'h0, irq_oe}, {3'h0, m[0]});
         host.read_reg(rtc_ctrl_pkg::ADDR_CONTROL, rd_val, rd_oe);
         check("second status", rd_val, {3'h0, m[0]});
         host.write_reg(rtc_ctrl_pkg::ADDR_CONTROL, 4'h7);
         repeat (50) @(negedge clk);
         check("irq halted", {3'h0, irq_oe}, 4'h0);
      end
      $display("test interval timer done");

      // running clock: one setting pulse, then one that lands inside a control read
      host.write_reg(rtc_ctrl_pkg::ADDR_CONTROL, 4'h1);
      repeat (40) @(negedge clk);
      check("tenths step", tenths_count, 4'h1);
      host.read_reg(rtc_ctrl_pkg::ADDR_CONTROL, rd_val, rd_oe);
      check("changed set", rd_val, 4'h8);
      for (int k = 0; k < 3; k++) begin
         host.read_reg(rtc_ctrl_pkg::ADDR_CONTROL, rd_val, rd_oe);
         check("changed clear", rd_val, 4'h0);
      end
      $display("test changed flag done");

      // reset in mid-run, with test mode on
      host.write_reg(rtc_ctrl_pkg::ADDR_CONTROL, 4'h8);
      @(negedge clk);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      idle_outputs();
      check("test cleared", {3'h0, test_mode}, 4'h0);
      host.read_reg(rtc_ctrl_pkg::ADDR_SETUP, rd_val, rd_oe);
      check("setup reset", rd_val, rtc_ctrl_pkg::SETUP_RESET);
      $display("test second reset done");
      summarize();
   end
endmodule
`default_nettype wire
